// ===== ssxe_pkg.sv
// Constants and types shared by the subtract/swap/skip/xor execution unit.
package ssxe_pkg;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    // Byte address width that the slave decodes.
    localparam int ADR_W = 13;
    localparam logic [ADR_W-1:0] A_COMMAND = 13'h0000;
    localparam logic [ADR_W-1:0] A_WORK_REGISTER = 13'h0004;
    localparam logic [ADR_W-1:0] A_STATUS = 13'h0008;
    localparam logic [ADR_W-1:0] A_TABLE_POINTER = 13'h000C;
    localparam logic [ADR_W-1:0] A_TABLE_HIGH_BYTE = 13'h0010;
    localparam logic [ADR_W-1:0] A_EXEC_STATE = 13'h0014;
    localparam logic [ADR_W-1:0] A_CODE_PAGE = 13'h0018;
    // Data memory window, one byte per word, 0x400 to 0x7FC.
    localparam logic [ADR_W-1:0] A_DMEM_BASE = 13'h0400;
    // Program memory window, one 16-bit word per word, 0x1000 up.
    localparam logic [ADR_W-1:0] A_PMEM_BASE = 13'h1000;

    // ****************************************************************
    // Memory geometry
    // ****************************************************************
    localparam int DMEM_AW = 8;
    localparam int DMEM_DEPTH = 256;
    localparam int PAGE_BITS = 2;
    localparam int PMEM_AW = PAGE_BITS + 8;
    localparam int PMEM_DEPTH = 1024;

    // ****************************************************************
    // Command word fields
    // ****************************************************************
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_ADR_LSB = 8;
    localparam int CMD_BIT_LSB = 16;
    localparam int CMD_IMM_LSB = 24;

    // ****************************************************************
    // Status flag positions; bits 7..4 are flags kept for the rest of the core.
    // ****************************************************************
    localparam int FLG_BORROW_INVERSE = 0;
    localparam int FLG_NIBBLE_CARRY = 1;
    localparam int FLG_RESULT_NULL = 2;
    localparam int FLG_SIGNED_RANGE = 3;

    // Execution state register fields.
    localparam int EX_SKIP_BIT = 0;
    localparam int EX_CYC_LSB = 1;
    localparam int EX_BUSY_BIT = 3;

    // ****************************************************************
    // Reset values and timing
    // ****************************************************************
    localparam logic [31:0] RST_COMMAND = 32'h00000000;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [PAGE_BITS-1:0] RST_PAGE = 2'h0;
    // Instruction length in cycles without and with a skip.
    localparam logic [1:0] CYC_PLAIN = 2'h1;
    localparam logic [1:0] CYC_SKIP = 2'h2;

    // Instruction codes written into the command register.
    typedef enum logic [3:0] {
        OP_SUB_MEM_TO_WORK = 4'b0000,
        OP_MINUS_INTO_MEMORY = 4'b0001,
        OP_SUB_IMM_TO_WORK = 4'b0010,
        OP_NIBBLE_EXCHANGE = 4'b0011,
        OP_NIBBLE_EXCHANGE_TO_WORK = 4'b0100,
        OP_SKIP_ON_ZERO = 4'b0101,
        OP_COPY_THEN_SKIP_ON_ZERO = 4'b0110,
        OP_SKIP_ON_BIT_ZERO = 4'b0111,
        OP_TABLE_READ_CURRENT_PAGE = 4'b1000,
        OP_TABLE_READ_LAST_PAGE = 4'b1001,
        OP_XOR_MEM_TO_WORK = 4'b1010,
        OP_EXCLUSIVE_OR_TO_MEMORY = 4'b1011,
        OP_XOR_IMM_TO_WORK = 4'b1100
    } ssxe_op_t;

    // Sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_DUMMY = 2'b10
    } ssxe_state_t;

endpackage

// ===== ssxe_alu.sv
// Combinational datapath for the subtract, swap, skip, table and xor instructions.
`timescale 1ns/1ps
module ssxe_alu
    import ssxe_pkg::*;
(
    // Decoded instruction.
    input wire ssxe_op_t op,
    input wire logic [2:0] bsel,
    input wire logic [7:0] imm,
    // Operands.
    input wire logic [7:0] work,
    input wire logic [7:0] mem,
    input wire logic [7:0] flags_in,
    input wire logic [15:0] rom_word,
    // Results and destinations.
    output logic [7:0] res,
    output logic [7:0] flags_out,
    output logic to_work,
    output logic to_mem,
    output logic to_table_high_byte,
    output logic skip
);

    // Subtract operand: immediate or memory byte.
    wire logic [7:0] opnd = (op == OP_SUB_IMM_TO_WORK) ? imm : mem;
    // Difference as work plus inverted operand plus one.
    wire logic [8:0] sum = {1'b0, work} + {1'b0, ~opnd} + 9'h001;
    // Low nibble sum, whose carry is the nibble carry.
    wire logic [4:0] lo = {1'b0, work[3:0]} + {1'b0, ~opnd[3:0]} + 5'h01;
    // Xor against immediate or memory.
    wire logic [7:0] xr = work ^ ((op == OP_XOR_IMM_TO_WORK) ? imm : mem);
    // Sign overflow when operand signs differ and the result sign leaves work's.
    wire logic ovf = (work[7] != opnd[7]) && (sum[7] != work[7]);

    // Every path starts from "no change" so untouched flags pass through.
    always_comb begin
        res = work;
        flags_out = flags_in;
        to_work = 1'b0;
        to_mem = 1'b0;
        to_table_high_byte = 1'b0;
        skip = 1'b0;
        unique case (op)
            OP_SUB_MEM_TO_WORK, OP_MINUS_INTO_MEMORY, OP_SUB_IMM_TO_WORK: begin
                res = sum[7:0];
                to_work = (op != OP_MINUS_INTO_MEMORY);
                to_mem = (op == OP_MINUS_INTO_MEMORY);
                flags_out[FLG_BORROW_INVERSE] = sum[8];
                flags_out[FLG_NIBBLE_CARRY] = lo[4];
                flags_out[FLG_RESULT_NULL] = (sum[7:0] == 8'h00);
                flags_out[FLG_SIGNED_RANGE] = ovf;
            end
            OP_NIBBLE_EXCHANGE: begin
                res = {mem[3:0], mem[7:4]};
                to_mem = 1'b1;
            end
            OP_NIBBLE_EXCHANGE_TO_WORK: begin
                res = {mem[3:0], mem[7:4]};
                to_work = 1'b1;
            end
            OP_SKIP_ON_ZERO: begin
                skip = (mem == 8'h00);
            end
            OP_COPY_THEN_SKIP_ON_ZERO: begin
                res = mem;
                to_work = 1'b1;
                skip = (mem == 8'h00);
            end
            OP_SKIP_ON_BIT_ZERO: begin
                skip = !mem[bsel];
            end
            OP_TABLE_READ_CURRENT_PAGE, OP_TABLE_READ_LAST_PAGE: begin
                res = rom_word[7:0];
                to_mem = 1'b1;
                to_table_high_byte = 1'b1;
            end
            OP_XOR_MEM_TO_WORK, OP_EXCLUSIVE_OR_TO_MEMORY, OP_XOR_IMM_TO_WORK: begin
                res = xr;
                to_work = (op != OP_EXCLUSIVE_OR_TO_MEMORY);
                to_mem = (op == OP_EXCLUSIVE_OR_TO_MEMORY);
                flags_out[FLG_RESULT_NULL] = (xr == 8'h00);
            end
            default: begin
                // Unused codes execute as a one-cycle no-operation.
            end
        endcase
    end

endmodule

// ===== ssxe_exec_top.sv
// Execution unit top: AHB-Lite register slave, data and program memory, sequencer.
// Contract
// - Subtract memory from work into work.
// - Subtract memory from work into memory.
// - Subtract immediate from work into work.
// - Subtracts update four flags, keep others.
// - Swap memory byte nibbles in place, no flags.
// - Swapped memory byte goes to work only.
// - Skip takes two cycles, else one.
// - Skip when memory byte is zero.
// - Copy byte to work, skip if zero.
// - Skip when selected memory bit is zero.
// - Current-page table read to memory and high byte.
// - Last-page table read to memory and high byte.
// - Xor memory into work, zero flag only.
// - Xor result into memory, zero flag only.
// - Xor immediate into work, zero flag only.
`timescale 1ns/1ps
module ssxe_exec_top
    import ssxe_pkg::*;
(
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite address phase.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    // AHB-Lite data phase.
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);

    // ****************************************************************
    // State
    // ****************************************************************
    // Address phase captured for the data phase.
    logic sel_q;
    logic wr_q;
    logic [ADR_W-1:0] adr_q;
    // A read waits one cycle so its data comes from a flip-flop.
    logic rd_pend_q;
    logic [31:0] hrdata_q;
    // Software-visible registers.
    logic [31:0] command_q;
    logic [7:0] work_register_q;
    logic [7:0] status_q;
    logic [7:0] table_pointer_q;
    logic [7:0] table_high_byte_q;
    logic [PAGE_BITS-1:0] code_page_q;
    // Outcome of the last instruction.
    logic last_skip_q;
    logic [1:0] last_cyc_q;
    // Sequencer.
    ssxe_state_t state_q;
    ssxe_state_t state_d;
    // Memories; no reset, software loads them over the bus.
    logic [7:0] dmem [DMEM_DEPTH];
    logic [15:0] pmem [PMEM_DEPTH];

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    // The bus idles us out only while the sequencer is not running.
    wire logic idle = (state_q == ST_IDLE);
    // A transfer is taken on NONSEQ or SEQ with the bus ready.
    wire logic accept = hsel && hready && htrans[1];
    // Write data are present on the edge that closes the data phase.
    wire logic bus_wr = sel_q && wr_q && hready;
    wire logic in_dmem = (adr_q[12:10] == A_DMEM_BASE[12:10]);
    wire logic in_pmem = (adr_q[12] == A_PMEM_BASE[12]);
    wire logic wr_cmd = bus_wr && (adr_q == A_COMMAND);
    wire logic wr_work = bus_wr && (adr_q == A_WORK_REGISTER);
    wire logic wr_stat = bus_wr && (adr_q == A_STATUS);
    wire logic wr_tptr = bus_wr && (adr_q == A_TABLE_POINTER);
    wire logic wr_page = bus_wr && (adr_q == A_CODE_PAGE);
    wire logic wr_dmem = bus_wr && in_dmem;
    wire logic wr_pmem = bus_wr && in_pmem;
    wire logic [DMEM_AW-1:0] bus_dadr = adr_q[DMEM_AW+1:2];
    wire logic [PMEM_AW-1:0] bus_padr = adr_q[PMEM_AW+1:2];

    // ****************************************************************
    // Instruction decode and operand fetch
    // ****************************************************************
    wire ssxe_op_t op = ssxe_op_t'(command_q[CMD_OP_LSB +: 4]);
    wire logic [DMEM_AW-1:0] madr = command_q[CMD_ADR_LSB +: DMEM_AW];
    wire logic [2:0] bsel = command_q[CMD_BIT_LSB +: 3];
    wire logic [7:0] imm = command_q[CMD_IMM_LSB +: 8];
    wire logic [7:0] mem_rd = dmem[madr];
    // The last page is the all-ones page; otherwise the current one.
    wire logic last_pg = (op == OP_TABLE_READ_LAST_PAGE);
    wire logic [PAGE_BITS-1:0] rom_pg = last_pg ? {PAGE_BITS{1'b1}} : code_page_q;
    wire logic [PMEM_AW-1:0] rom_adr = {rom_pg, table_pointer_q};
    wire logic [15:0] rom_word = pmem[rom_adr];
    // The instruction acts in the one execute cycle.
    wire logic exec = (state_q == ST_EXEC);

    // ALU results.
    logic [7:0] res;
    logic [7:0] flags_nx;
    logic to_work;
    logic to_mem;
    logic to_table_high_byte;
    logic skip;

    // ****************************************************************
    // Datapath
    // ****************************************************************
    ssxe_alu u_alu (
        .op(op),
        .bsel(bsel),
        .imm(imm),
        .work(work_register_q),
        .mem(mem_rd),
        .flags_in(status_q),
        .rom_word(rom_word),
        .res(res),
        .flags_out(flags_nx),
        .to_work(to_work),
        .to_mem(to_mem),
        .to_table_high_byte(to_table_high_byte),
        .skip(skip)
    );

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    // A skip adds one dummy cycle in place of the discarded prefetch.
    always_comb begin
        unique case (state_q)
            ST_IDLE: state_d = wr_cmd ? ST_EXEC : ST_IDLE;
            ST_EXEC: state_d = skip ? ST_DUMMY : ST_IDLE;
            ST_DUMMY: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    // Sequencer register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Record skip and length of each executed instruction.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_skip_q <= 1'b0;
            last_cyc_q <= CYC_PLAIN;
        end else if (exec) begin
            last_skip_q <= skip;
            last_cyc_q <= skip ? CYC_SKIP : CYC_PLAIN;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Address phase capture; held while the data phase is stalled.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_q <= 1'b0;
            wr_q <= 1'b0;
            adr_q <= '0;
        end else if (hready) begin
            sel_q <= accept;
            wr_q <= hwrite;
            adr_q <= haddr[ADR_W-1:0];
        end
    end

    // Command register; writing it starts the instruction.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            command_q <= RST_COMMAND;
        end else if (wr_cmd) begin
            command_q <= hwdata;
        end
    end

    // Work register: the instruction wins, software writes only when idle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            work_register_q <= RST_BYTE;
        end else if (exec && to_work) begin
            work_register_q <= res;
        end else if (wr_work) begin
            work_register_q <= hwdata[7:0];
        end
    end

    // Status flags; the ALU passes flags it does not own unchanged.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_q <= RST_BYTE;
        end else if (exec) begin
            status_q <= flags_nx;
        end else if (wr_stat) begin
            status_q <= hwdata[7:0];
        end
    end

    // Table pointer and code page, both software owned.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            table_pointer_q <= RST_BYTE;
            code_page_q <= RST_PAGE;
        end else begin
            if (wr_tptr) begin
                table_pointer_q <= hwdata[7:0];
            end
            if (wr_page) begin
                code_page_q <= hwdata[PAGE_BITS-1:0];
            end
        end
    end

    // Table high byte is loaded only by a table read.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            table_high_byte_q <= RST_BYTE;
        end else if (exec && to_table_high_byte) begin
            table_high_byte_q <= rom_word[15:8];
        end
    end

    // ****************************************************************
    // Memories
    // ****************************************************************
    // Bus and execute never collide: the bus is stalled while executing.
    always_ff @(posedge hclk) begin
        if (exec && to_mem) begin
            dmem[madr] <= res;
        end else if (wr_dmem) begin
            dmem[bus_dadr] <= hwdata[7:0];
        end
    end

    // Program memory is written by software, read by table reads.
    always_ff @(posedge hclk) begin
        if (wr_pmem) begin
            pmem[bus_padr] <= hwdata[15:0];
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    wire logic [31:0] ex_word = {28'h0000000, !idle, last_cyc_q, last_skip_q};
    wire logic [31:0] rd_mux =
        (adr_q == A_COMMAND) ? command_q :
        (adr_q == A_WORK_REGISTER) ? {24'h000000, work_register_q} :
        (adr_q == A_STATUS) ? {24'h000000, status_q} :
        (adr_q == A_TABLE_POINTER) ? {24'h000000, table_pointer_q} :
        (adr_q == A_TABLE_HIGH_BYTE) ? {24'h000000, table_high_byte_q} :
        (adr_q == A_EXEC_STATE) ? ex_word :
        (adr_q == A_CODE_PAGE) ? {30'h0, code_page_q} :
        in_dmem ? {24'h000000, dmem[bus_dadr]} :
        in_pmem ? {16'h0000, pmem[bus_padr]} :
        32'h00000000;

    // A read stays pending until the sequencer is idle, so it sees results.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_pend_q <= 1'b0;
        end else if (rd_pend_q) begin
            rd_pend_q <= !idle;
        end else begin
            rd_pend_q <= accept && !hwrite;
        end
    end

    // Read data register follows the selected word while pending.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h00000000;
        end else if (rd_pend_q) begin
            hrdata_q <= rd_mux;
        end
    end

    assign hrdata = hrdata_q;
    // Stalls cover the execute cycles and the read wait cycle.
    assign hreadyout = idle && !rd_pend_q;
    assign hresp = 1'b0;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_sub_work: assert property (
        exec && op == OP_SUB_MEM_TO_WORK |=>
        work_register_q == 8'($past(work_register_q) - $past(mem_rd)))
        else $error("subtract into work wrong");

    chk_sub_mem: assert property (
        exec && op == OP_MINUS_INTO_MEMORY |=>
        dmem[$past(madr)] == 8'($past(work_register_q) - $past(mem_rd))
        && $stable(work_register_q))
        else $error("subtract into memory wrong");

    chk_sub_imm: assert property (
        exec && op == OP_SUB_IMM_TO_WORK |=>
        work_register_q == 8'($past(work_register_q) - $past(imm)))
        else $error("subtract immediate wrong");

    chk_sub_flags: assert property (
        exec && (op == OP_SUB_MEM_TO_WORK || op == OP_MINUS_INTO_MEMORY) |=>
        status_q[7:4] == $past(status_q[7:4])
        && status_q[FLG_RESULT_NULL] == (8'($past(work_register_q)
        - $past(mem_rd)) == 8'h00))
        else $error("subtract flags wrong");

    chk_borrow_bit: assert property (
        exec && op == OP_SUB_MEM_TO_WORK |=>
        status_q[FLG_BORROW_INVERSE] == ($past(work_register_q) >= $past(mem_rd)))
        else $error("borrow bit wrong");

    chk_swap_mem: assert property (
        exec && op == OP_NIBBLE_EXCHANGE |=>
        dmem[$past(madr)] == {$past(mem_rd[3:0]), $past(mem_rd[7:4])}
        && $stable(status_q))
        else $error("nibble swap in memory wrong");

    chk_swap_work: assert property (
        exec && op == OP_NIBBLE_EXCHANGE_TO_WORK |=>
        work_register_q == {$past(mem_rd[3:0]), $past(mem_rd[7:4])}
        && dmem[$past(madr)] == $past(mem_rd))
        else $error("nibble swap to work wrong");

    chk_skip_time: assert property (
        exec && skip |=> state_q == ST_DUMMY ##1 state_q == ST_IDLE)
        else $error("skip not two cycles");

    chk_plain_time: assert property (
        exec && !skip |=> state_q == ST_IDLE && last_cyc_q == CYC_PLAIN)
        else $error("plain instruction not one cycle");

    chk_zero_skip: assert property (
        exec && op == OP_SKIP_ON_ZERO |->
        skip == (mem_rd == 8'h00) ##1 $stable(status_q))
        else $error("zero skip wrong");

    chk_copy_skip: assert property (
        exec && op == OP_COPY_THEN_SKIP_ON_ZERO |->
        skip == (mem_rd == 8'h00) ##1 work_register_q == $past(mem_rd))
        else $error("copy and skip wrong");

    chk_bit_skip: assert property (
        exec && op == OP_SKIP_ON_BIT_ZERO |-> skip == !mem_rd[bsel])
        else $error("bit skip wrong");

    chk_table_read: assert property (
        exec && (op == OP_TABLE_READ_CURRENT_PAGE || last_pg) |=>
        table_high_byte_q == $past(rom_word[15:8])
        && dmem[$past(madr)] == $past(rom_word[7:0]) && $stable(status_q))
        else $error("table read wrong");

    chk_xor_work: assert property (
        exec && op == OP_XOR_MEM_TO_WORK |=>
        work_register_q == ($past(work_register_q) ^ $past(mem_rd))
        && status_q[FLG_RESULT_NULL] == (work_register_q == 8'h00)
        && status_q[1:0] == $past(status_q[1:0]))
        else $error("xor into work wrong");

    chk_xor_mem: assert property (
        exec && op == OP_EXCLUSIVE_OR_TO_MEMORY |=>
        dmem[$past(madr)] == ($past(work_register_q) ^ $past(mem_rd))
        && $stable(work_register_q))
        else $error("xor into memory wrong");

    chk_xor_imm: assert property (
        exec && op == OP_XOR_IMM_TO_WORK |=>
        work_register_q == ($past(work_register_q) ^ $past(imm))
        && status_q[FLG_SIGNED_RANGE] == $past(status_q[FLG_SIGNED_RANGE]))
        else $error("xor immediate wrong");

endmodule

// ===== ssxe_master.sv
// Bus master model standing in front of the execution unit's register slave.
`timescale 1ns/1ps
module ssxe_master (
    // Clock and answer.
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Request, and a flag raised when an answer never came.
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [31:0] hwdata,
    output logic tmo
);
    // The bus is idle at time zero.
    initial {haddr, htrans, hwrite, hwdata, tmo} = '0;
    // Bounded wait for hready, so a stuck slave cannot hang the run.
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 40);
        if (hready !== 1'b1) tmo <= 1'b1;
    endtask
    // One word transfer; read data is taken at the edge ending the data phase.
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask
endmodule

// ===== sub_swap_skip_xor_exec_bench.sv
// Self-checking bench for the execution unit, driven over its register bus.
`timescale 1ns/1ps
module sub_swap_skip_xor_exec_bench import ssxe_pkg::*; ;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic hwrite, hreadyout, hresp, tmo;
    int err_count = 0;
    int n_compared = 0;
    // Byte 5 of data memory is the operand of every command.
    localparam logic [31:0] DM = 32'(A_DMEM_BASE) + 32'h00000014;
    localparam logic [31:0] WK = 32'(A_WORK_REGISTER);
    localparam logic [31:0] ST = 32'(A_STATUS);
    always #2.5 hclk = ~hclk;
    ssxe_exec_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
    ssxe_master m (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .tmo(tmo));
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        m.xfer(1'b1, a, d, rd);
    endtask
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] e);
        n_compared++;
        if (seen !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", s, e, seen);
        end
    endtask
    // Reads a register and compares it.
    task automatic rdc(input string s, input logic [31:0] a, input logic [31:0] e);
        m.xfer(1'b0, a, 32'h00000000, rd);
        chk(s, rd, e);
        chk("resp", 32'(hresp), 32'h00000000);
    endtask
    task automatic run(input logic [3:0] op, input logic [2:0] b, input logic [7:0] x);
        wr(32'(A_COMMAND), {x, 5'h00, b, 8'h05, 4'h0, op});
    endtask
    // Reference subtract: {overflow, zero, nibble carry, carry, result}.
    function automatic logic [11:0] sub_ref(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, ~b} + 9'h001;
        h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        return {(a[7] != b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
    endfunction
    // All three subtracts; upper status bits start set to catch stray writes.
    task automatic s_sub(input logic [7:0] a, input logic [7:0] b);
        logic [11:0] f;
        f = sub_ref(a, b);
        for (int op = 0; op < 3; op++) begin
            wr(WK, {24'h0, a});
            wr(DM, {24'h0, b});
            wr(ST, 32'h000000F0);
            run(4'(op), 3'h0, b);
            rdc("sub work", WK, {24'h0, op == 1 ? a : f[7:0]});
            rdc("sub mem", DM, {24'h0, op == 1 ? f[7:0] : b});
            rdc("sub flags", ST, {24'h0, 4'hF, f[11:8]});
        end
    endtask
    task automatic s_swap(input logic [7:0] v);
        wr(DM, {24'h0, v});
        wr(WK, 32'h0000005A);
        wr(ST, 32'h000000FF);
        run(4'(OP_NIBBLE_EXCHANGE), 3'h0, 8'h00);
        rdc("swap mem", DM, {24'h0, v[3:0], v[7:4]});
        rdc("swap work", WK, 32'h0000005A);
        run(4'(OP_NIBBLE_EXCHANGE_TO_WORK), 3'h0, 8'h00);
        rdc("swapw work", WK, {24'h0, v});
        rdc("swapw mem", DM, {24'h0, v[3:0], v[7:4]});
        rdc("swap flags", ST, 32'h000000FF);
    endtask
    // Execution state shows the length: 2 cycles with skip, 1 without.
    task automatic s_skip(input ssxe_op_t op, input logic [2:0] b, input logic [7:0] v,
                          input logic sk);
        wr(DM, {24'h0, v});
        wr(WK, 32'h000000C3);
        wr(ST, 32'h0000005A);
        run(4'(op), b, 8'h00);
        rdc("skip state", 32'(A_EXEC_STATE), sk ? 32'h00000005 : 32'h00000002);
        rdc("skip work", WK, {24'h0, op == OP_COPY_THEN_SKIP_ON_ZERO ? v : 8'hC3});
        rdc("skip mem", DM, {24'h0, v});
        rdc("skip flags", ST, 32'h0000005A);
    endtask
    // Words 0x233 (page 2) and 0x333 (last page), pointer 0x33.
    task automatic s_table();
        wr(32'(A_PMEM_BASE) + 32'h000008CC, 32'h0000A55A);
        wr(32'(A_PMEM_BASE) + 32'h00000CCC, 32'h00003CC3);
        wr(32'(A_CODE_PAGE), 32'h00000002);
        wr(32'(A_TABLE_POINTER), 32'h00000033);
        wr(32'(A_TABLE_HIGH_BYTE), 32'h000000EE);
        rdc("high ro", 32'(A_TABLE_HIGH_BYTE), 32'h00000000);
        run(4'(OP_TABLE_READ_CURRENT_PAGE), 3'h0, 8'h00);
        rdc("tab low", DM, 32'h0000005A);
        rdc("tab high", 32'(A_TABLE_HIGH_BYTE), 32'h000000A5);
        run(4'(OP_TABLE_READ_LAST_PAGE), 3'h0, 8'h00);
        rdc("tabl low", DM, 32'h000000C3);
        rdc("tabl high", 32'(A_TABLE_HIGH_BYTE), 32'h0000003C);
        run(4'hD, 3'h0, 8'h00);
        rdc("noop work", WK, 32'h000000C3);
        rdc("tab flags", ST, 32'h0000005A);
        rdc("unmapped", 32'h00000800, 32'h00000000);
    endtask
    task automatic s_xor(input logic [7:0] a, input logic [7:0] b);
        for (int op = 10; op < 13; op++) begin
            wr(WK, {24'h0, a});
            wr(DM, {24'h0, b});
            wr(ST, 32'h000000FF);
            run(4'(op), 3'h0, b);
            rdc("xor work", WK, {24'h0, op == 11 ? a : a ^ b});
            rdc("xor mem", DM, {24'h0, op == 11 ? a ^ b : b});
            rdc("xor flags", ST, {24'h0, 5'h1F, (a ^ b) == 8'h00, 2'h3});
        end
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // A transfer that never got its answer ends the run as a mismatch.
    always @(posedge tmo) begin
        err_count++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        s_sub(8'h10, 8'h20);
        s_sub(8'h80, 8'h01);
        s_sub(8'h3C, 8'h3C);
        s_sub(8'h7F, 8'hFF);
        s_swap(8'hA7);
        s_skip(OP_SKIP_ON_ZERO, 3'h0, 8'h00, 1'b1);
        s_skip(OP_SKIP_ON_ZERO, 3'h0, 8'h01, 1'b0);
        s_skip(OP_COPY_THEN_SKIP_ON_ZERO, 3'h0, 8'h00, 1'b1);
        s_skip(OP_COPY_THEN_SKIP_ON_ZERO, 3'h0, 8'h80, 1'b0);
        s_skip(OP_SKIP_ON_BIT_ZERO, 3'h3, 8'hF7, 1'b1);
        s_skip(OP_SKIP_ON_BIT_ZERO, 3'h3, 8'h08, 1'b0);
        s_skip(OP_SKIP_ON_BIT_ZERO, 3'h7, 8'h7F, 1'b1);
        s_table();
        s_xor(8'h96, 8'h3C);
        s_xor(8'h5A, 8'h5A);
        summarize();
    end
endmodule
